// ### design/csl_strap_ctrl.sv
// Strap latch and mode select for a system clock generator.
// Assumes board straps and a power-good level on pins outside this clock domain; a clock
// output is modelled as a registered level driven by a synchronous accumulator.
`timescale 1ns/1ps
module csl_strap_ctrl (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        clk_en,
  input  wire logic        freq_sel_bit0_in,
  output logic             freq_sel_bit0_out,
  output logic             freq_sel_bit0_oe,
  input  wire logic        freq_sel_bit1_in,
  output logic             freq_sel_bit1_out,
  output logic             freq_sel_bit1_oe,
  input  wire logic        freq_sel_bit2_in,
  output logic             freq_sel_bit2_out,
  output logic             freq_sel_bit2_oe,
  input  wire logic        freq_sel_bit3_in,
  output logic             freq_sel_bit3_out,
  output logic             freq_sel_bit3_oe,
  input  wire logic        cpu_family_strap_in,
  output logic             cpu_family_strap_out,
  output logic             cpu_family_strap_oe,
  input  wire logic        current_multiplier_strap_in,
  output logic             current_multiplier_strap_out,
  output logic             current_multiplier_strap_oe,
  input  wire logic        memory_mode_strap_in,
  output logic             memory_mode_strap_out,
  output logic             memory_mode_strap_oe,
  input  wire logic        core_power_good_n_in,
  output logic             core_power_good_n_out,
  output logic             core_power_good_n_oe,
  input  wire logic        crystal_input,
  input  wire logic        memory_buffer_in,
  input  wire logic        ref_a_strength_2x,
  input  wire logic        superio_select_48,
  output logic             cpu_clock_true_out,
  output logic             cpu_clock_true_oe,
  output logic             cpu_clock_comp_out,
  output logic             cpu_clock_comp_oe,
  output logic             graphics_port_clock,
  output logic             pci_clock,
  output logic      [5:0]  memory_clock_true,
  output logic      [5:0]  memory_clock_comp,
  output logic      [3:0]  freq_select_code,
  output logic             cpu_push_pull_mode,
  output logic             current_mult_6x,
  output logic             memory_single_rate,
  output logic             ref_a_drive_2x,
  output logic             clocks_enabled,
  output logic      [15:0] cpu_freq,
  output logic      [15:0] graphics_freq,
  output logic      [15:0] pci_freq
);

  // Pin synchronisers: bit order is fs0..fs3, family, mult, memory mode, power good,
  // crystal, buffer input.
  logic [9:0] pin_meta;
  logic [9:0] pin_sync;
  wire  [9:0] pin_raw = {memory_buffer_in, crystal_input, core_power_good_n_in,
                         memory_mode_strap_in, current_multiplier_strap_in,
                         cpu_family_strap_in, freq_sel_bit3_in, freq_sel_bit2_in,
                         freq_sel_bit1_in, freq_sel_bit0_in};

  wire [3:0] fs_sync      = pin_sync[3:0];
  wire       family_sync  = pin_sync[4];
  wire       mult_sync    = pin_sync[5];
  wire       memmode_sync = pin_sync[6];
  wire       pg_n_sync    = pin_sync[7];
  wire       crystal_sync = pin_sync[8];
  wire       buffer_sync  = pin_sync[9];

  csl_pkg::csl_state_e state;
  csl_pkg::csl_state_e next_state;
  logic [1:0]  settle_cnt;
  logic        straps_released;

  // One accumulator step; the top bit flags a wrap, which toggles the clock.
  function automatic logic [17:0] nco_step(input logic [16:0] acc, input logic [15:0] inc);
    logic [16:0] sum;
    sum = acc + {1'b0, inc};
    if (sum >= csl_pkg::NCO_LIMIT)
      nco_step = {1'b1, 17'(sum - csl_pkg::NCO_LIMIT)};
    else
      nco_step = {1'b0, sum};
  endfunction : nco_step

  wire settle_done = (state == csl_pkg::CSL_SETTLE) && (settle_cnt == csl_pkg::SETTLE_CYCLES);
  wire pg_event    = (state == csl_pkg::CSL_WAIT_PG) && !pg_n_sync;
  wire latch_all   = settle_done;
  wire relatch_pg  = pg_event;
  wire running     = (state == csl_pkg::CSL_RUN);

  always_comb
  begin
    next_state = state;
    case (state)
      csl_pkg::CSL_SETTLE:
        if (settle_done)
          next_state = family_sync ? csl_pkg::CSL_WAIT_PG : csl_pkg::CSL_RUN;
      csl_pkg::CSL_WAIT_PG:
        if (pg_event)
          next_state = csl_pkg::CSL_RUN;
      csl_pkg::CSL_RUN:
        next_state = csl_pkg::CSL_RUN;
      default:
        next_state = csl_pkg::CSL_SETTLE;
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      pin_meta <= 10'h000;
      pin_sync <= 10'h000;
    end
    else if (clk_en)
    begin
      pin_meta <= pin_raw;
      pin_sync <= pin_meta;
    end
  end

  // Reset release stands for the supply crossing; captures wait for the synchronisers.
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      state      <= csl_pkg::CSL_SETTLE;
      settle_cnt <= 2'h0;
    end
    else if (clk_en)
    begin
      state <= next_state;
      if (state == csl_pkg::CSL_SETTLE && settle_cnt != csl_pkg::SETTLE_CYCLES)
        settle_cnt <= settle_cnt + 2'h1;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      freq_select_code   <= csl_pkg::RST_FREQ_CODE;
      cpu_push_pull_mode <= csl_pkg::RST_STRAP;
      current_mult_6x    <= csl_pkg::RST_STRAP;
      memory_single_rate <= csl_pkg::RST_STRAP;
      straps_released    <= 1'b0;
    end
    else if (clk_en)
    begin
      if (latch_all)
      begin
        freq_select_code   <= fs_sync;
        cpu_push_pull_mode <= family_sync;
        current_mult_6x    <= mult_sync;
        memory_single_rate <= memmode_sync;
        straps_released    <= !family_sync;
      end
      else if (relatch_pg)
      begin
        freq_select_code <= fs_sync;
        current_mult_6x  <= mult_sync;
        straps_released  <= 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      ref_a_drive_2x <= csl_pkg::RST_REF_2X;
    else if (clk_en)
      ref_a_drive_2x <= ref_a_strength_2x;
  end

  // Frequency decode and synchronous synthesis of the table clocks.
  logic [15:0] tbl_cpu;
  logic [15:0] tbl_graphics;
  logic [15:0] tbl_pci;

  csl_freq_table u_table (
    .freq_select_code (freq_select_code),
    .cpu_freq         (tbl_cpu),
    .graphics_freq    (tbl_graphics),
    .pci_freq         (tbl_pci)
  );

  logic [16:0] acc_cpu;
  logic [16:0] acc_gfx;
  logic [16:0] acc_pci;
  logic [16:0] acc_usb;
  logic [16:0] acc_sio;
  logic        cpu_level;
  logic        gfx_level;
  logic        pci_level;
  logic        usb_level;
  logic        sio_level;

  wire [15:0] sio_inc  = superio_select_48 ? csl_pkg::SIO_FREQ_HIGH : csl_pkg::SIO_FREQ_LOW;
  wire [17:0] step_cpu = nco_step(acc_cpu, tbl_cpu);
  wire [17:0] step_gfx = nco_step(acc_gfx, tbl_graphics);
  wire [17:0] step_pci = nco_step(acc_pci, tbl_pci);
  wire [17:0] step_usb = nco_step(acc_usb, csl_pkg::USB_FREQ);
  wire [17:0] step_sio = nco_step(acc_sio, sio_inc);

  // All accumulators restart together when clocks start, which keeps them in step.
  always_ff @(posedge sys_clk)
  begin
    if (rst || !running)
    begin
      acc_cpu   <= csl_pkg::RST_ACC;
      acc_gfx   <= csl_pkg::RST_ACC;
      acc_pci   <= csl_pkg::RST_ACC;
      acc_usb   <= csl_pkg::RST_ACC;
      acc_sio   <= csl_pkg::RST_ACC;
      cpu_level <= 1'b0;
      gfx_level <= 1'b0;
      pci_level <= 1'b0;
      usb_level <= 1'b0;
      sio_level <= 1'b0;
    end
    else if (clk_en)
    begin
      acc_cpu   <= step_cpu[16:0];
      acc_gfx   <= step_gfx[16:0];
      acc_pci   <= step_pci[16:0];
      acc_usb   <= step_usb[16:0];
      acc_sio   <= step_sio[16:0];
      cpu_level <= cpu_level ^ step_cpu[17];
      gfx_level <= gfx_level ^ step_gfx[17];
      pci_level <= pci_level ^ step_pci[17];
      usb_level <= usb_level ^ step_usb[17];
      sio_level <= sio_level ^ step_sio[17];
    end
  end

  // Pin drive: shared pins stay inputs until their strap has been taken.
  wire od_mode = (cpu_push_pull_mode == csl_pkg::MODE_OPEN_DRAIN);
  wire pg_pin_as_ref = straps_released && od_mode && running;

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      freq_sel_bit0_out            <= 1'b0;
      freq_sel_bit0_oe             <= 1'b0;
      freq_sel_bit1_out            <= 1'b0;
      freq_sel_bit1_oe             <= 1'b0;
      freq_sel_bit2_out            <= 1'b0;
      freq_sel_bit2_oe             <= 1'b0;
      freq_sel_bit3_out            <= 1'b0;
      freq_sel_bit3_oe             <= 1'b0;
      cpu_family_strap_out         <= 1'b0;
      cpu_family_strap_oe          <= 1'b0;
      current_multiplier_strap_out <= 1'b0;
      current_multiplier_strap_oe  <= 1'b0;
      memory_mode_strap_out        <= 1'b0;
      memory_mode_strap_oe         <= 1'b0;
      core_power_good_n_out        <= 1'b0;
      core_power_good_n_oe         <= 1'b0;
    end
    else if (clk_en)
    begin
      freq_sel_bit0_out            <= running & crystal_sync;
      freq_sel_bit0_oe             <= running;
      freq_sel_bit1_out            <= pci_level;
      freq_sel_bit1_oe             <= running;
      freq_sel_bit2_out            <= sio_level;
      freq_sel_bit2_oe             <= running;
      freq_sel_bit3_out            <= usb_level;
      freq_sel_bit3_oe             <= running;
      cpu_family_strap_out         <= gfx_level;
      cpu_family_strap_oe          <= running;
      current_multiplier_strap_out <= pci_level;
      current_multiplier_strap_oe  <= running;
      memory_mode_strap_out        <= pci_level;
      memory_mode_strap_oe         <= running;
      core_power_good_n_out        <= pg_pin_as_ref & crystal_sync;
      core_power_good_n_oe         <= pg_pin_as_ref;
    end
  end

  // Processor pair: open-drain mode only pulls low, never drives high.
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      cpu_clock_true_out <= 1'b0;
      cpu_clock_true_oe  <= 1'b0;
      cpu_clock_comp_out <= 1'b0;
      cpu_clock_comp_oe  <= 1'b0;
    end
    else if (clk_en)
    begin
      if (!running)
      begin
        cpu_clock_true_out <= 1'b0;
        cpu_clock_true_oe  <= 1'b0;
        cpu_clock_comp_out <= 1'b0;
        cpu_clock_comp_oe  <= 1'b0;
      end
      else if (od_mode)
      begin
        cpu_clock_true_out <= 1'b0;
        cpu_clock_true_oe  <= !cpu_level;
        cpu_clock_comp_out <= 1'b0;
        cpu_clock_comp_oe  <= cpu_level;
      end
      else
      begin
        cpu_clock_true_out <= cpu_level;
        cpu_clock_true_oe  <= 1'b1;
        cpu_clock_comp_out <= !cpu_level;
        cpu_clock_comp_oe  <= 1'b1;
      end
    end
  end

  wire mem_double = (memory_single_rate == csl_pkg::MEM_DOUBLE_RATE);

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      graphics_port_clock <= 1'b0;
      pci_clock           <= 1'b0;
      memory_clock_true   <= 6'h00;
      memory_clock_comp   <= 6'h00;
      clocks_enabled      <= 1'b0;
      cpu_freq            <= 16'h0000;
      graphics_freq       <= 16'h0000;
      pci_freq            <= 16'h0000;
    end
    else if (clk_en)
    begin
      graphics_port_clock <= gfx_level;
      pci_clock           <= pci_level;
      memory_clock_true   <= {6{running & buffer_sync}};
      memory_clock_comp   <= {6{running & (buffer_sync ^ mem_double)}};
      clocks_enabled      <= running;
      cpu_freq            <= tbl_cpu;
      graphics_freq       <= tbl_graphics;
      pci_freq            <= tbl_pci;
    end
  end

endmodule : csl_strap_ctrl

// ### design/csl_pkg.sv
// Constants shared by the clock strap latch and mode select logic.
// Assumes a single 100 MHz system clock and a synchronous active-high reset.
package csl_pkg;

  // Cycles the pin synchronisers need before a strap level may be captured.
  localparam int unsigned SYNC_CYCLES   = 2;
  localparam logic [1:0]  SETTLE_CYCLES = 2'h2;

  // Strap values after reset, before the first capture.
  localparam logic [3:0]  RST_FREQ_CODE = 4'h0;
  localparam logic        RST_STRAP     = 1'h0;
  localparam logic        RST_REF_2X    = 1'h0;

  // Clock synthesis model: frequencies are in units of 10 kHz. Each output toggles
  // when its accumulator passes NCO_LIMIT, so the limit stands for 400 MHz.
  localparam logic [16:0] NCO_LIMIT     = 17'h0_9C40;
  localparam logic [15:0] USB_FREQ      = 16'h12C0;
  localparam logic [15:0] SIO_FREQ_LOW  = 16'h0960;
  localparam logic [15:0] SIO_FREQ_HIGH = 16'h12C0;
  localparam logic [16:0] RST_ACC       = 17'h0_0000;

  // Processor clock pair output types.
  localparam logic        MODE_OPEN_DRAIN = 1'h0;
  localparam logic        MODE_PUSH_PULL  = 1'h1;

  // Memory clock modes.
  localparam logic        MEM_DOUBLE_RATE = 1'h0;
  localparam logic        MEM_SINGLE_RATE = 1'h1;

  // Power-up sequencing states.
  typedef enum logic [2:0] {
    CSL_SETTLE  = 3'b001,
    CSL_WAIT_PG = 3'b010,
    CSL_RUN     = 3'b100
  } csl_state_e;

endpackage : csl_pkg

// ### design/csl_freq_table.sv
// Frequency table: maps the 4-bit select code to processor, graphics-port and PCI rates.
// Purely combinational; the caller registers the results. Rates are in 10 kHz units.
`timescale 1ns/1ps
module csl_freq_table (
  input  wire logic [3:0]  freq_select_code,
  output logic      [15:0] cpu_freq,
  output logic      [15:0] graphics_freq,
  output logic      [15:0] pci_freq
);

  always_comb
  begin
    case (freq_select_code)
      4'h0:    begin cpu_freq = 16'h1A18; graphics_freq = 16'h1A18; pci_freq = 16'h0D0C; end
      4'h1:    begin cpu_freq = 16'h2710; graphics_freq = 16'h1A18; pci_freq = 16'h0D0C; end
      4'h2:    begin cpu_freq = 16'h2EE0; graphics_freq = 16'h1770; pci_freq = 16'h0BB8; end
      4'h3:    begin cpu_freq = 16'h3415; graphics_freq = 16'h1A0B; pci_freq = 16'h0D05; end
      4'h4:    begin cpu_freq = 16'h1C20; graphics_freq = 16'h1C20; pci_freq = 16'h0E10; end
      4'h5:    begin cpu_freq = 16'h2904; graphics_freq = 16'h1B58; pci_freq = 16'h0DAC; end
      4'h6:    begin cpu_freq = 16'h3E80; graphics_freq = 16'h1900; pci_freq = 16'h0C80; end
      4'h7:    begin cpu_freq = 16'h36B0; graphics_freq = 16'h1B58; pci_freq = 16'h0DAC; end
      4'h8:    begin cpu_freq = 16'h1E14; graphics_freq = 16'h1E14; pci_freq = 16'h0F0A; end
      4'h9:    begin cpu_freq = 16'h2AF8; graphics_freq = 16'h1CA5; pci_freq = 16'h0E53; end
      4'hA:    begin cpu_freq = 16'h4650; graphics_freq = 16'h1770; pci_freq = 16'h0BB8; end
      4'hB:    begin cpu_freq = 16'h4114; graphics_freq = 16'h1A04; pci_freq = 16'h0D02; end
      4'hC:    begin cpu_freq = 16'h2328; graphics_freq = 16'h1770; pci_freq = 16'h0BB8; end
      4'hD:    begin cpu_freq = 16'h2710; graphics_freq = 16'h1A0B; pci_freq = 16'h0D05; end
      4'hE:    begin cpu_freq = 16'h4E20; graphics_freq = 16'h1A0B; pci_freq = 16'h0D05; end
      default: begin cpu_freq = 16'h3415; graphics_freq = 16'h1A0B; pci_freq = 16'h0D05; end
    endcase
  end

endmodule : csl_freq_table

// ### bench/csl_properties.sv
// Concurrent checks on the ports of the strap latch and mode select block.
// Assumes one clock domain with a synchronous active-high reset; bound to every instance.
`timescale 1ns/1ps
module csl_properties (
  input wire logic       sys_clk,
  input wire logic       rst,
  input wire logic       crystal_input,
  input wire logic       memory_buffer_in,
  input wire logic       ref_a_strength_2x,
  input wire logic       freq_sel_bit0_out,
  input wire logic       freq_sel_bit0_oe,
  input wire logic       freq_sel_bit3_oe,
  input wire logic       cpu_family_strap_oe,
  input wire logic       memory_mode_strap_oe,
  input wire logic       core_power_good_n_out,
  input wire logic       core_power_good_n_oe,
  input wire logic       cpu_clock_true_out,
  input wire logic       cpu_clock_true_oe,
  input wire logic       cpu_clock_comp_out,
  input wire logic       cpu_clock_comp_oe,
  input wire logic [5:0] memory_clock_true,
  input wire logic [5:0] memory_clock_comp,
  input wire logic [3:0] freq_select_code,
  input wire logic       cpu_push_pull_mode,
  input wire logic       current_mult_6x,
  input wire logic       memory_single_rate,
  input wire logic       ref_a_drive_2x,
  input wire logic       clocks_enabled
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  AST_REF_COPY:
    assert property (freq_sel_bit0_oe && $past(freq_sel_bit0_oe) |->
      freq_sel_bit0_out == $past(crystal_input, 3)) else $error("reference copy wrong");
  AST_PIN_TURN:
    assert property ({freq_sel_bit0_oe, freq_sel_bit3_oe, cpu_family_strap_oe,
      memory_mode_strap_oe} == {4{clocks_enabled}}) else $error("pin direction wrong");
  AST_PG_PIN:
    assert property (core_power_good_n_oe == (clocks_enabled && !cpu_push_pull_mode))
      else $error("power good pin direction wrong");
  AST_PG_COPY:
    assert property (core_power_good_n_oe && $past(core_power_good_n_oe) |->
      core_power_good_n_out == $past(crystal_input, 3)) else $error("second copy wrong");
  AST_CPU_PP:
    assert property (clocks_enabled && cpu_push_pull_mode |-> cpu_clock_true_oe &&
      cpu_clock_comp_oe && cpu_clock_comp_out != cpu_clock_true_out)
      else $error("push-pull pair wrong");
  AST_CPU_OD:
    assert property (clocks_enabled && !cpu_push_pull_mode |-> !cpu_clock_true_out &&
      !cpu_clock_comp_out && cpu_clock_true_oe != cpu_clock_comp_oe)
      else $error("open-drain pair wrong");
  AST_MEM_TRUE:
    assert property (clocks_enabled && $past(clocks_enabled) |->
      memory_clock_true == {6{$past(memory_buffer_in, 3)}}) else $error("memory true wrong");
  AST_MEM_COMP:
    assert property (clocks_enabled |-> memory_clock_comp ==
      (memory_single_rate ? memory_clock_true : ~memory_clock_true))
      else $error("memory complement wrong");
  AST_STRAP_HOLD:
    assert property (!$past(rst) && $past(clocks_enabled) |-> clocks_enabled &&
      $stable(freq_select_code) && $stable({cpu_push_pull_mode, current_mult_6x,
      memory_single_rate})) else $error("latched strap changed");
  AST_REF_STRENGTH:
    assert property (!$past(rst) |-> ref_a_drive_2x == $past(ref_a_strength_2x))
      else $error("strength select wrong");
endmodule : csl_properties

bind csl_strap_ctrl csl_properties u_props (
  .sys_clk(sys_clk), .rst(rst), .crystal_input(crystal_input),
  .memory_buffer_in(memory_buffer_in), .ref_a_strength_2x(ref_a_strength_2x),
  .freq_sel_bit0_out(freq_sel_bit0_out), .freq_sel_bit0_oe(freq_sel_bit0_oe),
  .freq_sel_bit3_oe(freq_sel_bit3_oe), .cpu_family_strap_oe(cpu_family_strap_oe),
  .memory_mode_strap_oe(memory_mode_strap_oe), .core_power_good_n_out(core_power_good_n_out),
  .core_power_good_n_oe(core_power_good_n_oe), .cpu_clock_true_out(cpu_clock_true_out),
  .cpu_clock_true_oe(cpu_clock_true_oe), .cpu_clock_comp_out(cpu_clock_comp_out),
  .cpu_clock_comp_oe(cpu_clock_comp_oe), .memory_clock_true(memory_clock_true),
  .memory_clock_comp(memory_clock_comp), .freq_select_code(freq_select_code),
  .cpu_push_pull_mode(cpu_push_pull_mode), .current_mult_6x(current_mult_6x),
  .memory_single_rate(memory_single_rate), .ref_a_drive_2x(ref_a_drive_2x),
  .clocks_enabled(clocks_enabled)
);

// ### bench/csl_board.sv
// Board side of the shared pins: strap resistors and the power-good source.
// Assumes the bench sets the strap levels; bit 7 is the power-good pin.
`timescale 1ns/1ps
module csl_board (
  input  wire logic [7:0] strap_val,
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe,
  output logic      [7:0] pin_lvl
);
  // A pin the device releases falls back to its strap resistor level.
  assign pin_lvl = (pin_oe & pin_out) | (~pin_oe & strap_val);
endmodule : csl_board

// ### bench/test_clock_strap_latch_and_mode_select.sv
// Self-checking bench for the strap latch and mode select block.
// Assumes the board model resolves the shared pins; runs every select code once.
`timescale 1ns/1ps
module test_clock_strap_latch_and_mode_select;
  logic        sys_clk, rst, xtal, buf_in, str2x, sio48;
  logic [7:0]  strap;
  wire  [7:0]  pin_out, pin_oe, pin_lvl;
  logic [5:0]  mct, mcc;
  logic [3:0]  code;
  logic        pp, m6, msr, r2x, en, gpc, pcc, ct, cto, cc, cco;
  logic [15:0] cf, gf, pf;
  logic [54:0] notes[$];
  logic [54:0] note;
  int          error_cnt, n_checks, en_cnt;
  logic [15:0] cpu_t[16] = '{16'h1A18, 16'h2710, 16'h2EE0, 16'h3415, 16'h1C20, 16'h2904,
    16'h3E80, 16'h36B0, 16'h1E14, 16'h2AF8, 16'h4650, 16'h4114, 16'h2328, 16'h2710,
    16'h4E20, 16'h3415};
  logic [15:0] agp_t[16] = '{16'h1A18, 16'h1A18, 16'h1770, 16'h1A0B, 16'h1C20, 16'h1B58,
    16'h1900, 16'h1B58, 16'h1E14, 16'h1CA5, 16'h1770, 16'h1A04, 16'h1770, 16'h1A0B,
    16'h1A0B, 16'h1A0B};
  logic [15:0] pci_t[16] = '{16'h0D0C, 16'h0D0C, 16'h0BB8, 16'h0D05, 16'h0E10, 16'h0DAC,
    16'h0C80, 16'h0DAC, 16'h0F0A, 16'h0E53, 16'h0BB8, 16'h0D02, 16'h0BB8, 16'h0D05,
    16'h0D05, 16'h0D05};

  csl_board u_board (.strap_val(strap), .pin_out(pin_out), .pin_oe(pin_oe), .pin_lvl(pin_lvl));

  csl_strap_ctrl DUT (
    .sys_clk(sys_clk), .rst(rst), .clk_en(1'b1),
    .freq_sel_bit0_in(pin_lvl[0]),
    .freq_sel_bit0_out(pin_out[0]), .freq_sel_bit0_oe(pin_oe[0]),
    .freq_sel_bit1_in(pin_lvl[1]),
    .freq_sel_bit1_out(pin_out[1]), .freq_sel_bit1_oe(pin_oe[1]),
    .freq_sel_bit2_in(pin_lvl[2]),
    .freq_sel_bit2_out(pin_out[2]), .freq_sel_bit2_oe(pin_oe[2]),
    .freq_sel_bit3_in(pin_lvl[3]),
    .freq_sel_bit3_out(pin_out[3]), .freq_sel_bit3_oe(pin_oe[3]),
    .cpu_family_strap_in(pin_lvl[4]),
    .cpu_family_strap_out(pin_out[4]), .cpu_family_strap_oe(pin_oe[4]),
    .current_multiplier_strap_in(pin_lvl[5]),
    .current_multiplier_strap_out(pin_out[5]), .current_multiplier_strap_oe(pin_oe[5]),
    .memory_mode_strap_in(pin_lvl[6]),
    .memory_mode_strap_out(pin_out[6]), .memory_mode_strap_oe(pin_oe[6]),
    .core_power_good_n_in(pin_lvl[7]),
    .core_power_good_n_out(pin_out[7]), .core_power_good_n_oe(pin_oe[7]),
    .crystal_input(xtal), .memory_buffer_in(buf_in),
    .ref_a_strength_2x(str2x), .superio_select_48(sio48),
    .cpu_clock_true_out(ct), .cpu_clock_true_oe(cto),
    .cpu_clock_comp_out(cc), .cpu_clock_comp_oe(cco),
    .graphics_port_clock(gpc), .pci_clock(pcc),
    .memory_clock_true(mct), .memory_clock_comp(mcc),
    .freq_select_code(code), .cpu_push_pull_mode(pp), .current_mult_6x(m6),
    .memory_single_rate(msr), .ref_a_drive_2x(r2x), .clocks_enabled(en),
    .cpu_freq(cf), .graphics_freq(gf), .pci_freq(pf)
  );

  task automatic finish_test();
    if (error_cnt == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : finish_test

  task automatic check(input logic [54:0] got, input logic [54:0] exp, input string msg);
    n_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask : check

  // Over 200 cycles a level whose rate r is in 10 kHz units toggles about r / 200 times.
  function automatic logic rate_ok(input int n, input int r);
    return n * 200 > r - 200 && n * 200 < r + 200;
  endfunction : rate_ok

  // One power-up: straps {mem, mult, family} random, select code c.
  task automatic run_case(input logic [3:0] c);
    logic [2:0]  s;
    logic [54:0] n;
    logic [8:0]  lv;
    logic [8:0]  nv;
    logic        ok;
    int          tg[9];
    int          rt[9];
    s = 3'($urandom);
    n = {c, s[0], s[1], s[2], cpu_t[c], agp_t[c], pci_t[c]};
    rst = 1'b1;
    // Push-pull mode starts with other levels, which the power-good event must replace.
    strap = {1'b1, s[2], s[1] ^ s[0], s[0], s[0] ? ~c : c};
    str2x = 1'($urandom);
    sio48 = 1'($urandom);
    repeat (10) @(negedge sys_clk);
    rst = 1'b0;
    notes.push_back(n);
    notes.push_back(n);
    repeat ($urandom_range(3, 8)) @(negedge sys_clk);
    if (s[0])
    begin
      check(55'(en), 55'(0), "enabled before power good");
      strap[5] = s[1];
      strap[3:0] = c;
      repeat (3) @(negedge sys_clk);
      strap[7] = 1'b0;
    end
    for (int k = 0; k < 40 && en !== 1'b1; k++) @(negedge sys_clk);
    check(55'(en), 55'(1), "clocks not enabled");
    strap = 8'($urandom);
    str2x = ~str2x;
    repeat (4) @(negedge sys_clk);
    strap[7] = ~strap[7];
    // Count toggles of the nine rate-checked clock pins; the open-drain true pin is read through its pull-up.
    rt = '{cpu_t[c], pci_t[c], agp_t[c], pci_t[c],
      sio48 ? csl_pkg::SIO_FREQ_HIGH : csl_pkg::SIO_FREQ_LOW, csl_pkg::USB_FREQ,
      agp_t[c], pci_t[c], pci_t[c]};
    tg = '{default: 0};
    lv = {pin_out[6:1], gpc, pcc, cto ? ct : 1'b1};
    repeat (200)
    begin
      @(negedge sys_clk);
      nv = {pin_out[6:1], gpc, pcc, cto ? ct : 1'b1};
      for (int j = 0; j < 9; j++)
        tg[j] += int'(nv[j] ^ lv[j]);
      lv = nv;
    end
    for (int j = 0; j < 9; j++)
    begin
      ok = rate_ok(tg[j], rt[j]);
      check(55'(ok), 55'(1), $sformatf("rate %0d", j));
    end
  endtask : run_case

  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // Crystal and buffer inputs run free with unrelated patterns.
  always @(negedge sys_clk)
  begin
    xtal <= ~xtal;
    buf_in <= buf_in ^ xtal ^ en_cnt[2];
  end

  // Results appear once clocks are enabled; each note is compared once.
  always @(negedge sys_clk)
  begin
    en_cnt <= (en === 1'b1) ? en_cnt + 1 : 0;
    if ((en_cnt == 1 || en_cnt == 12) && notes.size() > 0)
    begin
      note = notes.pop_front();
      check({code, pp, m6, msr, cf, gf, pf}, note, "latched straps or rates");
    end
  end

  initial
  begin
    repeat (6000) @(posedge sys_clk);
    error_cnt++;
    finish_test();
  end

  initial
  begin
    rst = 1'b1;
    strap = 8'h80;
    xtal = 1'b0;
    buf_in = 1'b0;
    str2x = 1'b0;
    sio48 = 1'b0;
    error_cnt = 0;
    n_checks = 0;
    en_cnt = 0;
    void'($urandom(32));
    for (int i = 0; i < 16; i++) run_case(4'(i));
    repeat (5) @(negedge sys_clk);
    finish_test();
  end
endmodule : test_clock_strap_latch_and_mode_select
